// ---- inc/apr_pkg.sv ----
package apr_pkg;
   localparam int NCORE = 2;
   localparam int INSTR_BITS = 16;
   localparam int DATA_BITS = 8;

   localparam logic [12:0] OFS_INDEX = 13'h005;
   localparam logic [12:0] OFS_XFER = 13'h0FF;
   localparam logic [12:0] OFS_MODE = 13'h008;
   localparam logic [12:0] OFS_CLOCK = 13'h009;
   localparam logic [12:0] OFS_TEST = 13'h00D;
   localparam logic [12:0] OFS_BUILT_IN_SELF_CHECK = 13'h00E;
   localparam logic [12:0] OFS_INPUT = 13'h00F;
   localparam logic [12:0] OFS_TRIM = 13'h010;
   localparam logic [12:0] OFS_OUTFMT = 13'h014;
   localparam logic [12:0] OFS_PHASE = 13'h016;
   localparam logic [12:0] OFS_REF = 13'h018;
   localparam logic [12:0] OFS_SIGLO = 13'h024;
   localparam logic [12:0] OFS_SIGHI = 13'h025;
   localparam logic [12:0] OFS_FINE = 13'h037;
   localparam logic [12:0] OFS_COARSE = 13'h038;

   localparam logic [7:0] MSK_INDEX = 8'h03;
   localparam logic [7:0] MSK_MODE = 8'h03;
   localparam logic [7:0] MSK_CLOCK = 8'h0B;
   localparam logic [7:0] MSK_TEST = 8'h37;
   localparam logic [7:0] MSK_BUILT_IN_SELF_CHECK = 8'h05;
   localparam logic [7:0] MSK_IN_GLB = 8'h02;
   localparam logic [7:0] MSK_IN_LOC = 8'h04;
   localparam logic [7:0] MSK_TRIM = 8'h0F;
   localparam logic [7:0] MSK_OUTFMT = 8'h17;
   localparam logic [7:0] MSK_PHASE = 8'h80;
   localparam logic [7:0] MSK_REF = 8'h1F;
   localparam logic [7:0] MSK_SKEW = 8'h0F;

   localparam logic [1:0] RST_INDEX = 2'h3;
   localparam logic [7:0] RST_MODE = 8'h00;
   localparam logic [7:0] RST_CLOCK = 8'h09;
   localparam logic [7:0] RST_TEST = 8'h00;
   localparam logic [7:0] RST_BUILT_IN_SELF_CHECK = 8'h00;
   localparam logic [7:0] RST_INPUT = 8'h02;
   localparam logic [7:0] RST_TRIM = 8'h00;
   localparam logic [7:0] RST_OUTFMT = 8'h00;
   localparam logic [7:0] RST_PHASE = 8'h00;
   localparam logic [7:0] RST_REF = 8'h00;
   localparam logic [7:0] RST_FINE = 8'h00;
   localparam logic [7:0] RST_COARSE = 8'h00;

   localparam int BIT_XFER = 0;
   localparam int BIT_SAMPLE = 3;
   localparam int BIT_BOOST = 1;
   localparam int BIT_DCS = 0;
   localparam int BIT_RST_LONG = 5;
   localparam int BIT_RST_SHORT = 4;
   localparam int BIT_BUILT_IN_SELF_CHECK_INIT = 2;
   localparam int BIT_BUILT_IN_SELF_CHECK_EN = 0;
   localparam int BIT_CM_EN = 1;
   localparam int BIT_DISC = 2;
   localparam int BIT_OUT_EN = 4;
   localparam int BIT_OUT_INV = 2;
   localparam int BIT_CLK_INV = 7;

   localparam logic [1:0] PWR_RUN = 2'h0;
   localparam logic [1:0] PWR_DOWN = 2'h1;
   localparam logic [4:0] REF_EXTERNAL = 5'h13;

   localparam real FINE_STEP_PS = 0.075;
   localparam real COARSE_STEP_PS = 1.2;
   localparam logic [14:0] FINE_STEP_FS = 15'(int'(FINE_STEP_PS * 1000.0));
   localparam logic [14:0] COARSE_STEP_FS =
      15'(int'(COARSE_STEP_PS * 1000.0));

   localparam logic [22:0] LONG_SEED = 23'h7FFFFF;
   localparam logic [8:0] SHORT_SEED = 9'h1FF;
   localparam logic [7:0] MIDSCALE = 8'h80;
   localparam logic [7:0] FULL_POS = 8'hFF;
   localparam logic [7:0] FULL_NEG = 8'h00;
   localparam logic [7:0] CHECKER = 8'h55;

   typedef enum logic [2:0] {
      PAT_OFF = 3'b000, PAT_MID = 3'b001, PAT_POS = 3'b010,
      PAT_NEG = 3'b011, PAT_CHECK = 3'b100, PAT_LONG = 3'b101,
      PAT_SHORT = 3'b110, PAT_TOGGLE = 3'b111
   } apr_pattern_t;

   typedef enum logic [1:0] {
      FMT_OFFSET = 2'b00, FMT_TWOS = 2'b01, FMT_GRAY = 2'b10
   } apr_format_t;

   typedef enum logic [1:0] {
      SPI_IDLE = 2'b00, SPI_INSTR = 2'b01, SPI_DATA = 2'b10
   } apr_spi_st_t;
endpackage

// ---- design/apr_core_path.sv ----
`timescale 1ns/10ps
`default_nettype none
module apr_core_path (
   input wire logic clk_i, // System clock
   input wire logic nrst_i, // Sync reset, active low
   input wire logic [7:0] sample_i, // Raw result, offset binary
   input wire logic valid_i, // Sample strobe
   input wire logic pwr_down_i, // Full power-down
   input wire logic [7:0] test_i, // Active test register
   input wire logic [7:0] built_in_self_check_i, // Active self-check register
   input wire logic [3:0] trim_i, // Offset trim, twos complement
   input wire logic [7:0] outfmt_i, // Active output mode register
   input wire logic [3:0] fine_i, // Fine skew code
   input wire logic [3:0] coarse_i, // Coarse skew code
   output logic [7:0] data_o, // Output word
   output logic den_o, // Output enabled
   output logic [15:0] sig_o, // Signature shift register
   output logic [14:0] skew_fs_o // Inserted delay, fs
);
   typedef struct packed {
      logic [22:0] pn_long;
      logic [8:0] pn_short;
      logic toggle;
      logic [15:0] sig;
      logic [7:0] dout;
      logic den;
      logic [14:0] skew;
   } apr_core_st_t;

   localparam apr_core_st_t CRST = '{pn_long: apr_pkg::LONG_SEED,
      pn_short: apr_pkg::SHORT_SEED, toggle: 1'b0, sig: 16'h0000,
      dout: 8'h00, den: 1'b0, skew: 15'h0000};

   apr_core_st_t s_r, s_nxt;
   logic [9:0] sum;
   logic [7:0] val;

   always_comb begin
      s_nxt = s_r;
      s_nxt.skew = 15'(fine_i) * apr_pkg::FINE_STEP_FS
         + 15'(coarse_i) * apr_pkg::COARSE_STEP_FS;
      sum = {2'b00, sample_i} + {{6{trim_i[3]}}, trim_i};
      if (sum[9]) begin
         val = 8'h00;
      end else if (sum[8]) begin
         val = 8'hFF;
      end else begin
         val = sum[7:0];
      end
      case (apr_pkg::apr_format_t'(outfmt_i[1:0]))
         apr_pkg::FMT_TWOS: val = val ^ 8'h80;
         apr_pkg::FMT_GRAY: val = val ^ (val >> 1);
         default: val = val;
      endcase
      if (outfmt_i[apr_pkg::BIT_OUT_INV]) begin
         val = ~val;
      end
      // Patterns bypass trim, format and inversion
      case (apr_pkg::apr_pattern_t'(test_i[2:0]))
         apr_pkg::PAT_MID: val = apr_pkg::MIDSCALE;
         apr_pkg::PAT_POS: val = apr_pkg::FULL_POS;
         apr_pkg::PAT_NEG: val = apr_pkg::FULL_NEG;
         apr_pkg::PAT_CHECK: val = s_r.toggle ? ~apr_pkg::CHECKER
            : apr_pkg::CHECKER;
         apr_pkg::PAT_LONG: val = s_r.pn_long[7:0];
         apr_pkg::PAT_SHORT: val = s_r.pn_short[7:0];
         apr_pkg::PAT_TOGGLE: val = {8{s_r.toggle}};
         default: val = val;
      endcase
      s_nxt.den = outfmt_i[apr_pkg::BIT_OUT_EN] & ~pwr_down_i;
      if (valid_i) begin
         s_nxt.pn_long = {s_r.pn_long[21:0],
            s_r.pn_long[22] ^ s_r.pn_long[17]};
         s_nxt.pn_short = {s_r.pn_short[7:0],
            s_r.pn_short[8] ^ s_r.pn_short[4]};
         s_nxt.toggle = ~s_r.toggle;
         s_nxt.dout = s_nxt.den ? val : 8'h00;
         if (built_in_self_check_i[apr_pkg::BIT_BUILT_IN_SELF_CHECK_EN]) begin
            s_nxt.sig = {s_r.sig[14:0],
               s_r.sig[15] ^ s_r.sig[4] ^ s_r.sig[2] ^ s_r.sig[1]}
               ^ {8'h00, s_nxt.dout};
         end
      end
      if (!s_nxt.den) begin
         s_nxt.dout = 8'h00;
      end
      // Generator resets are levels: the sequence stays at its seed
      if (test_i[apr_pkg::BIT_RST_LONG]) begin
         s_nxt.pn_long = apr_pkg::LONG_SEED;
      end
      if (test_i[apr_pkg::BIT_RST_SHORT]) begin
         s_nxt.pn_short = apr_pkg::SHORT_SEED;
      end
      if (built_in_self_check_i[apr_pkg::BIT_BUILT_IN_SELF_CHECK_INIT]) begin
         s_nxt.sig = 16'h0000;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         s_r <= CRST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign data_o = s_r.dout;
   assign den_o = s_r.den;
   assign sig_o = s_r.sig;
   assign skew_fs_o = s_r.skew;
endmodule // apr_core_path
`default_nettype wire

// ---- design/apr_register_bank.sv ----
// Behaviour
// - Power field: 00 runs, 01 powers down fully; 10 and 11 unused.
// - Sample mode bit: 0 interleaves the cores, 1 samples simultaneously.
// - Three-bit per-core pattern field picks normal data or one of seven output patterns.
// - Separate reset bits restart the long and short sequences.
// - Input register: local disconnect bit 2, global common-mode bit 1.
// - Four-bit offset trim is twos complement, -8 to +7.
// - Per-core output enable and invert bits act on the data outputs.
// - Format: 00 offset binary, 01 twos complement, 10 Gray code.
// - Reference register scales reference and input full scale.
// - Signature low byte is read only; writes do nothing.
// - Signature high byte is read only, forming a 16-bit signature.
// - Fine skew adds 0.075 ps per code step, up to 1.125 ps.
// - Coarse skew adds 1.2 ps per code step, up to 18 ps.
// - Fine plus coarse skew set each core's sampling delay.
// - Per-core writes reach only cores selected by the index register.
// - Written values other than the index become active only on the transfer command.
// - Reference field is bits 4:0; code 0x13 selects external reference.
`timescale 1ns/10ps
`default_nettype none
module apr_register_bank (
   input wire logic CLK_I, // System clock, 50 MHz
   input wire logic NRST_I, // Sync reset, active low
   input wire logic SCLK_I, // Serial clock from host
   input wire logic CSB_N_I, // Serial select, active low
   input wire logic SDIO_I, // Serial data in
   output logic SDIO_O, // Serial data out
   output logic SDIO_OE_N_O, // Low while driving serial data
   input wire logic [1:0][7:0] SAMPLE_I, // Raw core results
   input wire logic [1:0] SAMPLE_VALID_I, // Per-core sample strobe
   output logic [1:0][7:0] DATA_O, // Output words
   output logic [1:0] DATA_EN_O, // Per-core output enabled
   output logic [1:0][15:0] SIGNATURE_O, // Per-core signature
   output logic [1:0][14:0] SKEW_FS_O, // Per-core delay, fs
   output logic [1:0] DISCONNECT_O, // Per-core analog disconnect
   output logic POWER_DOWN_O, // Full power-down
   output logic SIMULTANEOUS_O, // Simultaneous sampling
   output logic CLOCK_BOOST_O, // Clock boost
   output logic DUTY_STAB_O, // Duty cycle stabilizer
   output logic CM_INPUT_EN_O, // Common-mode input enable
   output logic OUT_CLK_INV_O, // Invert output_data_clock
   output logic [4:0] REF_SCALE_O, // Reference scale code
   output logic EXT_REF_O // External reference selected
);
   typedef struct packed {
      logic [7:0] mode;
      logic [7:0] clk;
      logic [7:0] inp;
      logic [7:0] phase;
      logic [7:0] vref;
   } apr_glb_t;

   typedef struct packed {
      logic [7:0] test;
      logic [7:0] built_in_self_check;
      logic [7:0] inp;
      logic [7:0] trim;
      logic [7:0] ofmt;
      logic [7:0] fine;
      logic [7:0] coarse;
   } apr_loc_t;

   typedef struct packed {
      logic [2:0] sclk;
      logic [1:0] csb;
      logic [1:0] sdio;
      apr_pkg::apr_spi_st_t st;
      logic [4:0] cnt;
      logic [15:0] ins;
      logic rnw;
      logic [12:0] addr;
      logic [7:0] sh;
      logic [7:0] osh;
      logic oe_n;
      logic [1:0] idx;
      apr_glb_t g_sh;
      apr_glb_t g_act;
      apr_loc_t [1:0] l_sh;
      apr_loc_t [1:0] l_act;
   } apr_bank_st_t;

   localparam apr_glb_t GRST = '{mode: apr_pkg::RST_MODE,
      clk: apr_pkg::RST_CLOCK,
      inp: apr_pkg::RST_INPUT & apr_pkg::MSK_IN_GLB,
      phase: apr_pkg::RST_PHASE, vref: apr_pkg::RST_REF};
   localparam apr_loc_t LRST = '{test: apr_pkg::RST_TEST,
      built_in_self_check: apr_pkg::RST_BUILT_IN_SELF_CHECK,
      inp: apr_pkg::RST_INPUT & apr_pkg::MSK_IN_LOC,
      trim: apr_pkg::RST_TRIM, ofmt: apr_pkg::RST_OUTFMT,
      fine: apr_pkg::RST_FINE, coarse: apr_pkg::RST_COARSE};
   localparam apr_bank_st_t BRST = '{sclk: 3'h0, csb: 2'h3,
      sdio: 2'h0, st: apr_pkg::SPI_IDLE, cnt: 5'h00, ins: 16'h0000,
      rnw: 1'b0, addr: 13'h0000, sh: 8'h00, osh: 8'h00, oe_n: 1'b1,
      idx: apr_pkg::RST_INDEX, g_sh: GRST, g_act: GRST,
      l_sh: '{LRST, LRST}, l_act: '{LRST, LRST}};

   localparam logic [4:0] LAST_INSTR = 5'(apr_pkg::INSTR_BITS - 1);
   localparam logic [4:0] LAST_DATA = 5'(apr_pkg::DATA_BITS - 1);

   apr_bank_st_t s_r, s_nxt;
   logic rise, fall;
   logic [15:0] word;
   logic [7:0] byte_in;
   logic [1:0][15:0] sig;

   // Local reads come from the lowest selected core
   function automatic logic [7:0] rd(input logic [12:0] a,
         input apr_bank_st_t s, input logic [1:0][15:0] sg);
      logic c;
      c = ~s.idx[0];
      case (a)
         apr_pkg::OFS_INDEX: rd = {6'h00, s.idx};
         apr_pkg::OFS_MODE: rd = s.g_sh.mode;
         apr_pkg::OFS_CLOCK: rd = s.g_sh.clk;
         apr_pkg::OFS_TEST: rd = s.l_sh[c].test;
         apr_pkg::OFS_BUILT_IN_SELF_CHECK: rd = s.l_sh[c].built_in_self_check;
         apr_pkg::OFS_INPUT: rd = s.g_sh.inp | s.l_sh[c].inp;
         apr_pkg::OFS_TRIM: rd = s.l_sh[c].trim;
         apr_pkg::OFS_OUTFMT: rd = s.l_sh[c].ofmt;
         apr_pkg::OFS_PHASE: rd = s.g_sh.phase;
         apr_pkg::OFS_REF: rd = s.g_sh.vref;
         apr_pkg::OFS_SIGLO: rd = sg[c][7:0];
         apr_pkg::OFS_SIGHI: rd = sg[c][15:8];
         apr_pkg::OFS_FINE: rd = s.l_sh[c].fine;
         apr_pkg::OFS_COARSE: rd = s.l_sh[c].coarse;
         default: rd = 8'h00;
      endcase
   endfunction

   // Only the second and third stages are looked at for edges
   assign rise = s_r.sclk[1] & ~s_r.sclk[2];
   assign fall = ~s_r.sclk[1] & s_r.sclk[2];
   assign word = {s_r.ins[14:0], s_r.sdio[1]};
   assign byte_in = {s_r.sh[6:0], s_r.sdio[1]};

   always_comb begin
      s_nxt = s_r;
      s_nxt.sclk = {s_r.sclk[1:0], SCLK_I};
      s_nxt.csb = {s_r.csb[0], CSB_N_I};
      s_nxt.sdio = {s_r.sdio[0], SDIO_I};
      if (s_r.csb[1]) begin
         s_nxt.st = apr_pkg::SPI_IDLE;
         s_nxt.cnt = 5'h00;
         s_nxt.oe_n = 1'b1;
      end else begin
         case (s_r.st)
            apr_pkg::SPI_IDLE: begin
               s_nxt.st = apr_pkg::SPI_INSTR;
               s_nxt.cnt = 5'h00;
            end
            apr_pkg::SPI_INSTR: begin
               if (rise) begin
                  s_nxt.ins = word;
                  s_nxt.cnt = s_r.cnt + 5'h01;
                  if (s_r.cnt == LAST_INSTR) begin
                     s_nxt.cnt = 5'h00;
                     s_nxt.rnw = word[15];
                     s_nxt.addr = word[12:0];
                     s_nxt.st = apr_pkg::SPI_DATA;
                     if (word[15]) begin
                        s_nxt.osh = rd(word[12:0], s_r, sig);
                        s_nxt.oe_n = 1'b0;
                     end
                  end
               end
            end
            apr_pkg::SPI_DATA: begin
               // No shift right after a byte: its first bit must stay
               if (fall && s_r.cnt != 5'h00) begin
                  s_nxt.osh = {s_r.osh[6:0], 1'b0};
               end
               if (rise) begin
                  s_nxt.sh = byte_in;
                  s_nxt.cnt = s_r.cnt + 5'h01;
                  if (s_r.cnt == LAST_DATA) begin
                     s_nxt.cnt = 5'h00;
                     s_nxt.addr = s_r.addr - 13'h0001;
                     if (s_r.rnw) begin
                        s_nxt.osh = rd(s_r.addr - 13'h0001, s_r, sig);
                     end else begin
                        case (s_r.addr)
                           apr_pkg::OFS_INDEX:
                              s_nxt.idx = byte_in[1:0];
                           apr_pkg::OFS_XFER: begin
                              if (byte_in[apr_pkg::BIT_XFER]) begin
                                 s_nxt.g_act = s_r.g_sh;
                                 s_nxt.l_act = s_r.l_sh;
                              end
                           end
                           apr_pkg::OFS_MODE: s_nxt.g_sh.mode =
                              byte_in & apr_pkg::MSK_MODE;
                           apr_pkg::OFS_CLOCK: s_nxt.g_sh.clk =
                              byte_in & apr_pkg::MSK_CLOCK;
                           apr_pkg::OFS_INPUT: s_nxt.g_sh.inp =
                              byte_in & apr_pkg::MSK_IN_GLB;
                           apr_pkg::OFS_PHASE: s_nxt.g_sh.phase =
                              byte_in & apr_pkg::MSK_PHASE;
                           apr_pkg::OFS_REF: s_nxt.g_sh.vref =
                              byte_in & apr_pkg::MSK_REF;
                           default: s_nxt.idx = s_r.idx;
                        endcase
                        for (int c = 0; c < apr_pkg::NCORE; c++) begin
                           if (s_r.idx[c]) begin
                              case (s_r.addr)
                                 apr_pkg::OFS_TEST: s_nxt.l_sh[c].test =
                                    byte_in & apr_pkg::MSK_TEST;
                                 apr_pkg::OFS_BUILT_IN_SELF_CHECK: s_nxt.l_sh[c].built_in_self_check =
                                    byte_in & apr_pkg::MSK_BUILT_IN_SELF_CHECK;
                                 apr_pkg::OFS_INPUT: s_nxt.l_sh[c].inp =
                                    byte_in & apr_pkg::MSK_IN_LOC;
                                 apr_pkg::OFS_TRIM: s_nxt.l_sh[c].trim =
                                    byte_in & apr_pkg::MSK_TRIM;
                                 apr_pkg::OFS_OUTFMT: s_nxt.l_sh[c].ofmt =
                                    byte_in & apr_pkg::MSK_OUTFMT;
                                 apr_pkg::OFS_FINE: s_nxt.l_sh[c].fine =
                                    byte_in & apr_pkg::MSK_SKEW;
                                 apr_pkg::OFS_COARSE:
                                    s_nxt.l_sh[c].coarse =
                                    byte_in & apr_pkg::MSK_SKEW;
                                 default: s_nxt.l_sh[c] = s_r.l_sh[c];
                              endcase
                           end
                        end
                     end
                  end
               end
            end
            default: s_nxt.st = apr_pkg::SPI_IDLE;
         endcase
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!NRST_I) begin
         s_r <= BRST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign SDIO_O = s_r.osh[7];
   assign SDIO_OE_N_O = s_r.oe_n;
   assign POWER_DOWN_O = s_r.g_act.mode[1:0] == apr_pkg::PWR_DOWN;
   assign SIMULTANEOUS_O = s_r.g_act.clk[apr_pkg::BIT_SAMPLE];
   assign CLOCK_BOOST_O = s_r.g_act.clk[apr_pkg::BIT_BOOST];
   assign DUTY_STAB_O = s_r.g_act.clk[apr_pkg::BIT_DCS];
   assign CM_INPUT_EN_O = s_r.g_act.inp[apr_pkg::BIT_CM_EN];
   assign OUT_CLK_INV_O = s_r.g_act.phase[apr_pkg::BIT_CLK_INV];
   assign REF_SCALE_O = s_r.g_act.vref[4:0];
   assign EXT_REF_O = s_r.g_act.vref[4:0] == apr_pkg::REF_EXTERNAL;
   assign SIGNATURE_O = sig;

   for (genvar c = 0; c < apr_pkg::NCORE; c++) begin : g_core
      assign DISCONNECT_O[c] = s_r.l_act[c].inp[apr_pkg::BIT_DISC];
      apr_core_path u_path (
         .clk_i(CLK_I),
         .nrst_i(NRST_I),
         .sample_i(SAMPLE_I[c]),
         .valid_i(SAMPLE_VALID_I[c]),
         .pwr_down_i(POWER_DOWN_O),
         .test_i(s_r.l_act[c].test),
         .built_in_self_check_i(s_r.l_act[c].built_in_self_check),
         .trim_i(s_r.l_act[c].trim[3:0]),
         .outfmt_i(s_r.l_act[c].ofmt),
         .fine_i(s_r.l_act[c].fine[3:0]),
         .coarse_i(s_r.l_act[c].coarse[3:0]),
         .data_o(DATA_O[c]),
         .den_o(DATA_EN_O[c]),
         .sig_o(sig[c]),
         .skew_fs_o(SKEW_FS_O[c])
      );
   end
endmodule // apr_register_bank
`default_nettype wire

// ---- dv/apr_bank_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module apr_bank_sva (
   input wire logic CLK_I, // System clock
   input wire logic NRST_I, // Sync reset, active low
   input wire logic CSB_N_I, // Serial select
   input wire logic SDIO_OE_N_O, // Serial drive enable
   input wire logic [1:0] SAMPLE_VALID_I, // Sample strobes
   input wire logic [1:0][7:0] DATA_O, // Output words
   input wire logic [1:0] DATA_EN_O, // Output enables
   input wire logic [1:0][15:0] SIGNATURE_O, // Signatures
   input wire logic [1:0][14:0] SKEW_FS_O, // Delays in fs
   input wire logic POWER_DOWN_O, // Power-down
   input wire logic [4:0] REF_SCALE_O, // Reference code
   input wire logic EXT_REF_O // External reference
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!NRST_I);
   sequence s_pd_held;
      POWER_DOWN_O [*2];
   endsequence
   sequence s_off_held;
      !DATA_EN_O[0] [*2];
   endsequence
   a_pd_no_out: assert property (s_pd_held |-> DATA_EN_O == 2'b00)
      else $error("outputs enabled in power-down");
   a_ext_ref: assert property (
      $stable(REF_SCALE_O) |-> EXT_REF_O == (REF_SCALE_O == 5'h13))
      else $error("external reference flag wrong");
   a_skew_grid: assert property (
      SKEW_FS_O[0] % 75 == 0 && SKEW_FS_O[1] % 75 == 0 &&
      SKEW_FS_O[0] <= 19125 && SKEW_FS_O[1] <= 19125)
      else $error("skew off the step grid");
   a_off_zero: assert property (s_off_held |-> DATA_O[0] == 8'h00)
      else $error("disabled output not zero");
   a_data_hold: assert property (
      !$past(SAMPLE_VALID_I[0]) && $past(DATA_EN_O[0]) && DATA_EN_O[0]
      |-> $stable(DATA_O[0])) else $error("output moved without sample");
   a_sig_cause: assert property (
      $changed(SIGNATURE_O[0]) |-> $past(SAMPLE_VALID_I[0]) ||
      SIGNATURE_O[0] == 16'h0000) else $error("signature moved alone");
   a_ctl_frame: assert property (
      $changed(POWER_DOWN_O) || $changed(REF_SCALE_O) |->
      $past(CSB_N_I) == 1'b0) else $error("control changed off frame");
   a_oe_idle: assert property (CSB_N_I [*8] |-> SDIO_OE_N_O)
      else $error("serial data driven while deselected");
endmodule // apr_bank_sva
bind apr_register_bank apr_bank_sva u_sva (.CLK_I(CLK_I),
   .NRST_I(NRST_I), .CSB_N_I(CSB_N_I), .SDIO_OE_N_O(SDIO_OE_N_O),
   .SAMPLE_VALID_I(SAMPLE_VALID_I), .DATA_O(DATA_O),
   .DATA_EN_O(DATA_EN_O), .SIGNATURE_O(SIGNATURE_O),
   .SKEW_FS_O(SKEW_FS_O), .POWER_DOWN_O(POWER_DOWN_O),
   .REF_SCALE_O(REF_SCALE_O), .EXT_REF_O(EXT_REF_O));
`default_nettype wire

// ---- dv/apr_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module apr_host_model (
   input wire logic clk_i, // System clock
   input wire logic dev_sdio_i, // Device serial data
   input wire logic dev_oe_n_i, // Low while device drives
   output logic sclk_o, // Serial clock, idle low
   output logic csb_n_o, // Serial select, active low
   output logic sdio_o // Wire level
);
   logic drv = 1'b1;
   logic bit_q = 1'b0;
   logic idle_q = 1'b0;
   initial begin
      sclk_o = 1'b0;
      csb_n_o = 1'b1;
   end
   // No pull on the wire: a released line must not keep old data
   always @(posedge clk_i) if (!drv) idle_q <= ~idle_q;
   assign sdio_o = !dev_oe_n_i ? dev_sdio_i : (drv ? bit_q : idle_q);
   task automatic frame(input logic rdn, input logic [12:0] adr,
         input logic [7:0] wd, output logic [7:0] rdat);
      logic [23:0] sh;
      sh = {rdn, 2'b00, adr, wd};
      rdat = 8'h00;
      @(posedge clk_i) csb_n_o <= 1'b0;
      for (int i = 23; i >= 0; i--) begin
         @(posedge clk_i);
         sclk_o <= 1'b0;
         bit_q <= sh[i];
         drv <= !(rdn && i < 8);
         repeat (4) @(posedge clk_i);
         sclk_o <= 1'b1;
         if (i < 8) rdat[i] = sdio_o;
         repeat (3) @(posedge clk_i);
      end
      @(posedge clk_i);
      sclk_o <= 1'b0;
      drv <= 1'b1;
      repeat (4) @(posedge clk_i);
      csb_n_o <= 1'b1;
      repeat (6) @(posedge clk_i);
   endtask
endmodule // apr_host_model
`default_nettype wire

// ---- dv/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [1:0][7:0] smp = '0;
   logic [1:0] vld = 2'b00;
   wire logic sclk, csb_n, sdi, sdo, oe_n, pd, sim, bst, stab, cm, cinv;
   wire logic eref;
   wire logic [1:0][7:0] dat;
   wire logic [1:0] den, disc;
   wire logic [1:0][15:0] sig;
   wire logic [1:0][14:0] skw;
   wire logic [4:0] rsc;
   int err_total = 0;
   int num_checks = 0;
   logic [7:0] rd, d1;
   logic [15:0] s;
   logic [12:0] ofs [13] = '{13'h008, 13'h009, 13'h00D, 13'h00E,
      13'h00F, 13'h010, 13'h014, 13'h016, 13'h018, 13'h024, 13'h025,
      13'h037, 13'h038};
   logic [7:0] rv [13] = '{8'h00, 8'h09, 8'h00, 8'h00, 8'h02, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0] wv [13] = '{8'hFD, 8'hF7, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
      8'hFE, 8'hFF, 8'hF3, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
   logic [7:0] ev [13] = '{8'h01, 8'h03, 8'h37, 8'h05, 8'h06, 8'h0F,
      8'h16, 8'h80, 8'h13, 8'h00, 8'h00, 8'h0F, 8'h0F};
   logic [7:0] pv [3] = '{8'h80, 8'hFF, 8'h00};
   logic [7:0] pc [2] = '{8'h04, 8'h07};
   logic [7:0] pr [3] = '{8'h35, 8'h16, 8'h26};
   always #10 clk = ~clk;
   apr_register_bank uut (.CLK_I(clk), .NRST_I(nrst), .SCLK_I(sclk),
      .CSB_N_I(csb_n), .SDIO_I(sdi), .SDIO_O(sdo), .SDIO_OE_N_O(oe_n),
      .SAMPLE_I(smp), .SAMPLE_VALID_I(vld), .DATA_O(dat),
      .DATA_EN_O(den), .SIGNATURE_O(sig), .SKEW_FS_O(skw),
      .DISCONNECT_O(disc), .POWER_DOWN_O(pd), .SIMULTANEOUS_O(sim),
      .CLOCK_BOOST_O(bst), .DUTY_STAB_O(stab), .CM_INPUT_EN_O(cm),
      .OUT_CLK_INV_O(cinv), .REF_SCALE_O(rsc), .EXT_REF_O(eref));
   apr_host_model host (.clk_i(clk), .dev_sdio_i(sdo),
      .dev_oe_n_i(oe_n), .sclk_o(sclk), .csb_n_o(csb_n), .sdio_o(sdi));
   task automatic chk(input string nm, input logic [15:0] sn, ex);
      num_checks++;
      if (sn !== ex) begin
         err_total++;
         $display("[ERR] %s exp %h seen %h", nm, ex, sn);
      end
   endtask
   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      host.frame(1'b0, a, d, rd);
   endtask
   task automatic rchk(input logic [12:0] a, input logic [7:0] e);
      host.frame(1'b1, a, 8'h00, rd);
      chk("reg", {8'h00, rd}, {8'h00, e});
   endtask
   task automatic xfer;
      wr(13'h0FF, 8'h01);
   endtask
   task automatic pulse(input logic [7:0] v);
      @(posedge clk);
      smp <= {v, v};
      vld <= 2'b11;
      @(posedge clk);
      vld <= 2'b00;
      @(negedge clk);
   endtask
   function automatic logic [7:0] fexp(input logic [1:0] f,
         input logic inv, input logic [7:0] v);
      logic [7:0] o;
      o = (f == 2'b01) ? v ^ 8'h80 : (f == 2'b10) ? v ^ (v >> 1) : v;
      return inv ? ~o : o;
   endfunction
   function automatic logic [15:0] sstep(input logic [15:0] q,
         input logic [7:0] d);
      return {q[14:0], q[15] ^ q[4] ^ q[2] ^ q[1]} ^ {8'h00, d};
   endfunction
   task automatic test_done;
      if (err_total == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Whole run needs about 0.4 ms of serial traffic
   initial begin
      #1000000;
      err_total++;
      test_done();
   end
   initial begin
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
      chk("ctl", 16'({sim, stab, cm, pd}), 16'h000E);
      rchk(13'h005, 8'h03);
      rchk(13'h003, 8'h00);
      foreach (ofs[i]) rchk(ofs[i], rv[i]);
      foreach (ofs[i]) begin
         wr(ofs[i], wv[i]);
         rchk(ofs[i], ev[i]);
      end
      chk("pre", 16'({pd, cinv, rsc}), 16'h0000);
      xfer();
      chk("post", 16'({pd, sim, bst, stab, cm, cinv, eref, rsc}),
         16'h0BF3);
      chk("disc", 16'({disc, den}), 16'h000C);
      chk("skew", 16'(skw[1]), 16'(15 * 75 + 15 * 1200));
      wr(13'h005, 8'h02);
      wr(13'h010, 8'h07);
      wr(13'h037, 8'h00);
      rchk(13'h010, 8'h07);
      wr(13'h005, 8'h01);
      rchk(13'h010, 8'h0F);
      xfer();
      chk("skw0", 16'(skw[0]), 16'(15 * 75 + 15 * 1200));
      chk("skw1", 16'(skw[1]), 16'(15 * 1200));
      wr(13'h005, 8'h03);
      wr(13'h008, 8'h00);
      wr(13'h014, 8'h10);
      wr(13'h00D, 8'h00);
      wr(13'h00E, 8'h00);
      xfer();
      pulse(8'hFC);
      chk("trim", dat, {8'hFF, 8'hFB});
      pulse(8'h00);
      chk("trim", dat, {8'h07, 8'h00});
      chk("den", 16'(den), 16'h0003);
      wr(13'h010, 8'h08);
      xfer();
      pulse(8'h80);
      chk("trim", dat, {8'h78, 8'h78});
      wr(13'h010, 8'h00);
      for (int f = 0; f < 6; f++) begin
         wr(13'h014, {3'b000, 1'b1, 1'b0, 1'(f / 3), 2'(f % 3)});
         xfer();
         pulse(8'h93);
         chk("fmt", 16'(dat[0]),
            16'(fexp(2'(f % 3), 1'(f / 3), 8'h93)));
      end
      wr(13'h014, 8'h14);
      foreach (pv[i]) begin
         wr(13'h00D, 8'(i + 1));
         xfer();
         pulse(8'h12);
         chk("pat", 16'(dat[0]), 16'(pv[i]));
      end
      foreach (pc[i]) begin
         wr(13'h00D, pc[i]);
         xfer();
         pulse(8'h12);
         d1 = dat[0];
         pulse(8'h12);
         chk("alt", 16'(dat[0] ^ d1), 16'h00FF);
      end
      foreach (pr[i]) begin
         wr(13'h00D, pr[i]);
         xfer();
         repeat (3) pulse(8'h12);
         chk("prbs", 16'(dat[0] == 8'hFF), 16'(i < 2));
      end
      wr(13'h00D, 8'h00);
      wr(13'h014, 8'h10);
      wr(13'h00E, 8'h01);
      xfer();
      pulse(8'h55);
      wr(13'h00E, 8'h05);
      xfer();
      pulse(8'h55);
      chk("sig", sig[0], 16'h0000);
      wr(13'h00E, 8'h01);
      xfer();
      s = 16'h0000;
      pulse(8'h12);
      s = sstep(s, 8'h12);
      pulse(8'h34);
      s = sstep(s, 8'h34);
      chk("sig", sig[0], s);
      wr(13'h024, 8'hAA);
      rchk(13'h024, s[7:0]);
      rchk(13'h025, s[15:8]);
      test_done();
   end
endmodule // testbench
`default_nettype wire
